// File: hw/pcias_pkg.sv
/*
 * Constants shared by the PCI arbitration and system-error block: register
 * offsets, field positions, reset values and the hold handshake states.
 * Assumes a 32-bit APB register bus with byte addresses on paddr.
 */
// Function
// - system error output is driven only while the global enable bit is set
// - target abort on an own cycle gives exactly one clock of system error
// - address parity error needs parity response, global and path enables
// - sampled parity error signal raises system error when its path enabled
// - graphics-port system error input raises system error when enabled
// - on hold request, flush and disable posted writes before granting
// - hold acknowledge only once posted buffers are empty and disabled
// - three active-low requests in, three active-low grants out
// - data moves only while target-ready is asserted
// - stop from the target makes the master end the transaction
package pcias_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned NREQ   = 3;

    localparam logic [7:0] OFF_PCI_CMD  = 8'h04;
    localparam logic [7:0] OFF_ERR_CMD  = 8'h0C;
    localparam logic [7:0] OFF_INT_STAT = 8'h10;
    localparam logic [7:0] OFF_INT_MASK = 8'h14;
    localparam logic [7:0] OFF_STATUS   = 8'h18;
    localparam logic [7:0] OFF_PAR_SERR = 8'h90;

    // pci_command_reg fields
    localparam int unsigned BIT_PAR_RESP = 6;
    localparam int unsigned BIT_SERR_EN  = 8;
    // error_command_reg fields
    localparam int unsigned BIT_PERR_SERR = 3;
    localparam int unsigned BIT_GFX_SERR  = 5;
    // parity-to-system-error enable register field
    localparam int unsigned BIT_PAR_SERR = 0;

    // interrupt status / mask layout
    localparam int unsigned EVT_SERR     = 0;
    localparam int unsigned EVT_HOLD_ACK = 1;
    localparam int unsigned EVT_TABORT   = 2;
    localparam int unsigned NEVT         = 3;

    // status register layout
    localparam int unsigned ST_HOLD_LSB = 0;
    localparam int unsigned ST_EMPTY    = 2;
    localparam int unsigned ST_GNT_LSB  = 4;

    localparam logic [31:0] RST_PCI_CMD  = 32'h0000_0000;
    localparam logic [31:0] RST_ERR_CMD  = 32'h0000_0000;
    localparam logic [31:0] RST_PAR_SERR = 32'h0000_0000;
    localparam logic [2:0]  RST_INT_MASK = 3'h0;

    typedef enum logic [1:0] {
        HOLD_IDLE  = 2'b00,
        HOLD_FLUSH = 2'b01,
        HOLD_ACK   = 2'b11,
        HOLD_DONE  = 2'b10
    } pcias_hold_type;
endpackage

// File: hw/pcias_arbiter.sv
/*
 * Round-robin arbiter for three PCI masters, one-hot grant from flops.
 * Assumes requests are already synchronised and active high.
 */
module pcias_arbiter (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] req,
    input  wire logic       block,
    output logic      [2:0] gnt
);
    logic [1:0] last_r;
    logic [2:0] gnt_nxt;

    // first requester after the last owner, wrapping round
    function automatic logic [2:0] rr_pick(input logic [2:0] r,
                                           input logic [1:0] last);
        logic [2:0] g;
        logic [1:0] idx;
        g = 3'h0;
        for (int i = 2; i >= 0; i--) begin
            // modulo in int width, a 2-bit sum would wrap at four
            idx = 2'((int'(last) + i + 1) % 3);
            if (r[idx]) begin
                g = 3'h0;
                g[idx] = 1'b1;
            end
        end
        return g;
    endfunction

    always_comb begin
        gnt_nxt = 3'h0;
        if (block) begin
            gnt_nxt = 3'h0;
        end else if (gnt != 3'h0) begin
            // owner keeps it; otherwise an empty cycle before handing over
            gnt_nxt = gnt & req;
        end else begin
            gnt_nxt = rr_pick(req, last_r);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gnt <= 3'h0;
        end else begin
            gnt <= gnt_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_r <= 2'd2;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (gnt_nxt[i]) begin
                    last_r <= 2'(i);
                end
            end
        end
    end
endmodule

// File: hw/pcias_serr.sv
/*
 * System-error source combiner: enabled one-clock causes give one-clock
 * assertions of the system error pin. Assumes causes are one-cycle pulses.
 */
module pcias_serr (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic tabort_pulse,
    input  wire logic apar_pulse,
    input  wire logic perr_pulse,
    input  wire logic gfx_pulse,
    input  wire logic global_en,
    input  wire logic par_resp_en,
    input  wire logic par_serr_en,
    input  wire logic perr_serr_en,
    input  wire logic gfx_serr_en,
    output logic      serr_r
);
    logic serr_nxt;

    always_comb begin
        serr_nxt = tabort_pulse
                 | (apar_pulse & par_resp_en & par_serr_en)
                 | (perr_pulse & perr_serr_en)
                 | (gfx_pulse & gfx_serr_en);
        serr_nxt = serr_nxt & global_en;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serr_r <= 1'b0;
        end else begin
            serr_r <= serr_nxt;
        end
    end
endmodule

// File: hw/pcias_top.sv
/*
 * PCI arbitration, ISA hold handshake and system-error reporting with an
 * APB register file and a level interrupt. Assumes pclk is the PCI clock,
 * bus pins are asynchronous to logic and are synchronised here; own_cycle,
 * addr_par_err and post_buf_empty come from logic on pclk.
 */
// Local design decisions: the register offsets and the APB register port.
module pcias_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  req_n,
    output logic      [2:0]  gnt_n,
    input  wire logic        isa_hold_req_n,
    output logic             isa_hold_ack_n,
    input  wire logic        gfx_sys_err_in_n,
    input  wire logic        perr_n,
    input  wire logic        devsel_n,
    input  wire logic        trdy_n,
    input  wire logic        stop_n,
    input  wire logic        frame_n,
    input  wire logic        irdy_n,
    input  wire logic        own_cycle,
    input  wire logic        addr_par_err,
    input  wire logic        post_buf_empty,
    output logic             post_flush,
    output logic             post_disable,
    output logic             serr_o,
    output logic             serr_oe,
    output logic             data_beat,
    output logic             master_stop,
    output logic             irq
);
    localparam int unsigned NSYNC = 9;

    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    logic [NSYNC-1:0] pins;
    logic [2:0]  req_s;
    logic        hold_req_s;
    logic        gfx_s;
    logic        perr_s;
    logic        devsel_s;
    logic        trdy_s;
    logic        stop_s;
    logic        frame_s;
    logic        irdy_s;

    logic [31:0] pci_cmd_r;
    logic [31:0] err_cmd_r;
    logic [31:0] par_serr_r;
    logic [2:0]  int_stat_r;
    logic [2:0]  int_mask_r;

    pcias_pkg::pcias_hold_type hold_r;
    pcias_pkg::pcias_hold_type hold_nxt;

    logic [2:0]  gnt;
    logic        block;
    logic        bus_idle;
    logic        tabort_lvl;
    logic        tabort_prev_r;
    logic        perr_prev_r;
    logic        gfx_prev_r;
    logic        tabort_pulse;
    logic        perr_pulse;
    logic        gfx_pulse;
    logic        serr_r;
    logic        data_beat_r;
    logic        master_stop_r;
    logic [2:0]  evt;
    logic        acc;
    logic        wr;
    logic        mapped;
    logic [31:0] rdata;

    // pins are active low; invert once and synchronise as high-true levels
    assign pins = {~req_n, ~isa_hold_req_n, ~gfx_sys_err_in_n, ~perr_n,
                   ~devsel_n, ~trdy_n, ~stop_n};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    assign {req_s, hold_req_s, gfx_s, perr_s, devsel_s, trdy_s, stop_s} =
        sync2_r;

    // frame and irdy kept as separate high-true idle levels
    logic [1:0] idle1_r;
    logic [1:0] idle2_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle1_r <= 2'b11;
            idle2_r <= 2'b11;
        end else begin
            idle1_r <= {frame_n, irdy_n};
            idle2_r <= idle1_r;
        end
    end

    assign frame_s  = ~idle2_r[1];
    assign irdy_s   = ~idle2_r[0];
    assign bus_idle = ~frame_s & ~irdy_s;

    // hold handshake with the ISA bridge
    always_comb begin
        hold_nxt = hold_r;
        unique case (hold_r)
            pcias_pkg::HOLD_IDLE: begin
                if (hold_req_s) begin
                    hold_nxt = pcias_pkg::HOLD_FLUSH;
                end
            end
            pcias_pkg::HOLD_FLUSH: begin
                // grants withdrawn and posted data drained before the ack
                if (post_buf_empty && gnt == 3'h0 && bus_idle) begin
                    hold_nxt = pcias_pkg::HOLD_ACK;
                end
            end
            pcias_pkg::HOLD_ACK: begin
                // bridge keeps request low until granted, then releases
                if (!hold_req_s) begin
                    hold_nxt = pcias_pkg::HOLD_DONE;
                end
            end
            pcias_pkg::HOLD_DONE: begin
                hold_nxt = pcias_pkg::HOLD_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= pcias_pkg::HOLD_IDLE;
        end else begin
            hold_r <= hold_nxt;
        end
    end

    // posting stays off for the whole hold so nothing slips in after flush
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_flush     <= 1'b0;
            post_disable   <= 1'b0;
            isa_hold_ack_n <= 1'b1;
        end else begin
            post_flush     <= (hold_nxt == pcias_pkg::HOLD_FLUSH);
            post_disable   <= (hold_nxt == pcias_pkg::HOLD_FLUSH) ||
                              (hold_nxt == pcias_pkg::HOLD_ACK);
            isa_hold_ack_n <= ~(hold_nxt == pcias_pkg::HOLD_ACK);
        end
    end

    assign block = (hold_r != pcias_pkg::HOLD_IDLE);

    pcias_arbiter u_arb (
        .pclk    (pclk),
        .presetn (presetn),
        .req     (req_s),
        .block   (block),
        .gnt     (gnt)
    );

    assign gnt_n = ~gnt;

    // error causes other than addr_par_err, each turned into a one-clock pulse on its leading edge
    assign tabort_lvl = own_cycle & stop_s & ~devsel_s & ~trdy_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tabort_prev_r <= 1'b0;
            perr_prev_r   <= 1'b0;
            gfx_prev_r    <= 1'b0;
        end else begin
            tabort_prev_r <= tabort_lvl;
            perr_prev_r   <= perr_s;
            gfx_prev_r    <= gfx_s;
        end
    end

    assign tabort_pulse = tabort_lvl & ~tabort_prev_r;
    assign perr_pulse   = perr_s & ~perr_prev_r;
    assign gfx_pulse    = gfx_s & ~gfx_prev_r;

    pcias_serr u_serr (
        .pclk         (pclk),
        .presetn      (presetn),
        .tabort_pulse (tabort_pulse),
        .apar_pulse   (addr_par_err),
        .perr_pulse   (perr_pulse),
        .gfx_pulse    (gfx_pulse),
        .global_en    (pci_cmd_r[pcias_pkg::BIT_SERR_EN]),
        .par_resp_en  (pci_cmd_r[pcias_pkg::BIT_PAR_RESP]),
        .par_serr_en  (par_serr_r[pcias_pkg::BIT_PAR_SERR]),
        .perr_serr_en (err_cmd_r[pcias_pkg::BIT_PERR_SERR]),
        .gfx_serr_en  (err_cmd_r[pcias_pkg::BIT_GFX_SERR]),
        .serr_r       (serr_r)
    );

    // open-drain style: only ever pulls low
    assign serr_o  = 1'b0;
    assign serr_oe = serr_r;

    // own-cycle data tracking for the master side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_beat_r   <= 1'b0;
            master_stop_r <= 1'b0;
        end else begin
            data_beat_r   <= own_cycle & trdy_s & irdy_s;
            master_stop_r <= own_cycle & stop_s;
        end
    end

    assign data_beat   = data_beat_r;
    assign master_stop = master_stop_r;

    // APB slave, zero wait states
    assign acc    = psel & penable;
    assign wr     = acc & pwrite;
    assign pready = 1'b1;

    always_comb begin
        mapped = 1'b1;
        rdata  = 32'h0000_0000;
        unique case (paddr)
            pcias_pkg::OFF_PCI_CMD:  rdata = pci_cmd_r;
            pcias_pkg::OFF_ERR_CMD:  rdata = err_cmd_r;
            pcias_pkg::OFF_PAR_SERR: rdata = par_serr_r;
            pcias_pkg::OFF_INT_STAT: rdata = {29'h0, int_stat_r};
            pcias_pkg::OFF_INT_MASK: rdata = {29'h0, int_mask_r};
            pcias_pkg::OFF_STATUS: begin
                rdata[pcias_pkg::ST_HOLD_LSB +: 2] = hold_r;
                rdata[pcias_pkg::ST_EMPTY]         = post_buf_empty;
                rdata[pcias_pkg::ST_GNT_LSB +: 3]  = gnt;
            end
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = acc & ~mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pci_cmd_r  <= pcias_pkg::RST_PCI_CMD;
            err_cmd_r  <= pcias_pkg::RST_ERR_CMD;
            par_serr_r <= pcias_pkg::RST_PAR_SERR;
            int_mask_r <= pcias_pkg::RST_INT_MASK;
        end else if (wr) begin
            if (paddr == pcias_pkg::OFF_PCI_CMD) begin
                pci_cmd_r <= pwdata;
            end
            if (paddr == pcias_pkg::OFF_ERR_CMD) begin
                err_cmd_r <= pwdata;
            end
            if (paddr == pcias_pkg::OFF_PAR_SERR) begin
                par_serr_r <= pwdata;
            end
            if (paddr == pcias_pkg::OFF_INT_MASK) begin
                int_mask_r <= pwdata[2:0];
            end
        end
    end

    // sticky events; a new event beats a write-one-to-clear in the same cycle
    assign evt[pcias_pkg::EVT_SERR]     = serr_r;
    assign evt[pcias_pkg::EVT_HOLD_ACK] =
        (hold_r == pcias_pkg::HOLD_FLUSH) && (hold_nxt == pcias_pkg::HOLD_ACK);
    assign evt[pcias_pkg::EVT_TABORT]   = tabort_pulse;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_r <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (evt[i]) begin
                    int_stat_r[i] <= 1'b1;
                end else if (wr && paddr == pcias_pkg::OFF_INT_STAT &&
                             pwdata[i]) begin
                    int_stat_r[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat_r & int_mask_r);
        end
    end
endmodule

// File: testbench/pcias_props.sv
/*
 * Port-level checker for pcias_top, bound after the module.
 * Assumes pclk is the only clock and presetn an async active-low reset.
 */
module pcias_props (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic [2:0] req_n,
    input wire logic [2:0] gnt_n,
    input wire logic       isa_hold_req_n,
    input wire logic       isa_hold_ack_n,
    input wire logic       trdy_n,
    input wire logic       stop_n,
    input wire logic       post_disable,
    input wire logic       serr_o,
    input wire logic       serr_oe,
    input wire logic       data_beat,
    input wire logic       master_stop
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    one_grant_a: assert property ($onehot0(~gnt_n))
        else $error("more than one grant");
    ack_no_grant_a: assert property (
        !isa_hold_ack_n |-> gnt_n == 3'h7)
        else $error("grant during hold ack");
    ack_disabled_a: assert property (
        !isa_hold_ack_n |-> post_disable)
        else $error("hold ack with posting enabled");
    ack_late_a: assert property (
        $fell(isa_hold_ack_n) |-> $past(isa_hold_req_n, 3) == 1'b0)
        else $error("hold ack too early");
    flush_start_a: assert property (
        $fell(isa_hold_req_n) |-> ##[1:4] post_disable)
        else $error("no flush after hold request");
    disable_gnt_a: assert property (
        post_disable |=> gnt_n == 3'h7)
        else $error("grant while posting disabled");
    grant_req_a: assert property (
        (~gnt_n & $past(req_n, 3)) == 3'h0)
        else $error("grant without request");
    ack_release_a: assert property (
        $rose(isa_hold_req_n) && !isa_hold_ack_n |-> ##[1:4] isa_hold_ack_n)
        else $error("hold ack not released");
    beat_trdy_a: assert property (
        data_beat |-> $past(trdy_n, 3) == 1'b0)
        else $error("data beat without target ready");
    stop_end_a: assert property (
        master_stop |-> $past(stop_n, 3) == 1'b0)
        else $error("master stop without stop");
    serr_pull_a: assert property (serr_o == 1'b0)
        else $error("serr pin driven high");

    cover property ($fell(isa_hold_ack_n));
    cover property (serr_oe);
    cover property (data_beat);
    cover property (master_stop);
endmodule

bind pcias_top pcias_props pcias_props_inst (.pclk, .presetn, .req_n,
    .gnt_n, .isa_hold_req_n, .isa_hold_ack_n, .trdy_n, .stop_n,
    .post_disable, .serr_o, .serr_oe, .data_beat, .master_stop);

// File: testbench/pcias_isa_model.sv
/*
 * ISA bridge hold requester and CPU-to-PCI posted write buffer.
 * Assumes the bench raises go and fill for one cycle after a rising edge.
 */
module pcias_isa_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic       fill,
    input  wire logic [3:0] fill_n,
    input  wire logic [3:0] hold_len,
    input  wire logic       isa_hold_ack_n,
    input  wire logic       post_flush,
    input  wire logic       post_disable,
    output logic            isa_hold_req_n,
    output logic            post_buf_empty
);
    logic [3:0] depth_r;
    logic [3:0] held_r;

    assign post_buf_empty = (depth_r == 4'h0);

    // one entry drains per flush cycle, so a deep buffer answers slowly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth_r <= 4'h0;
        end else if (fill && !post_disable) begin
            depth_r <= fill_n;
        end else if (post_flush && depth_r != 4'h0) begin
            depth_r <= depth_r - 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            isa_hold_req_n <= 1'b1;
            held_r         <= 4'h0;
        end else if (go) begin
            isa_hold_req_n <= 1'b0;
            held_r         <= 4'h0;
        end else if (!isa_hold_req_n && !isa_hold_ack_n) begin
            held_r <= held_r + 4'h1;
            if (held_r == hold_len) begin
                isa_hold_req_n <= 1'b1;
            end
        end
    end
endmodule

// File: testbench/pcias_top_tb_top.sv
/*
 * Self-checking bench for pcias_top: apb tasks, integer reference for the
 * system-error paths, arbitration order and the hold handshake.
 * Assumes pcias_props is bound and pcias_isa_model sits on the far side.
 */
module pcias_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, isa_hold_req_n, isa_hold_ack_n;
    logic [2:0]  req_n = 3'h7;
    logic [2:0]  gnt_n;
    logic        gfx_sys_err_in_n = 1'b1;
    logic        perr_n = 1'b1;
    logic        devsel_n = 1'b1;
    logic        trdy_n = 1'b1;
    logic        stop_n = 1'b1;
    logic        frame_n = 1'b1;
    logic        irdy_n = 1'b1;
    logic        own_cycle = 1'b0;
    logic        addr_par_err = 1'b0;
    logic        post_buf_empty, post_flush, post_disable, serr_o, serr_oe;
    logic        data_beat, master_stop, irq;
    logic        go = 1'b0;
    logic        fill = 1'b0;
    logic [3:0]  fill_n = 4'h0;
    logic [3:0]  hold_len = 4'hF;
    logic [31:0] seed = 32'h0001_0FF6;
    logic [31:0] r, q;
    logic [2:0]  g3;
    logic        e;
    int          err_count = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          serr_seen = 0;
    int          s0, cause, xs;
    logic [7:0]  offs [6] = '{pcias_pkg::OFF_PCI_CMD, pcias_pkg::OFF_ERR_CMD,
        pcias_pkg::OFF_PAR_SERR, pcias_pkg::OFF_INT_STAT,
        pcias_pkg::OFF_INT_MASK, pcias_pkg::OFF_STATUS};
    // status idles with only the buffer-empty bit up
    logic [31:0] rstv [6] = '{pcias_pkg::RST_PCI_CMD, pcias_pkg::RST_ERR_CMD,
        pcias_pkg::RST_PAR_SERR, 32'h0000_0000,
        32'(pcias_pkg::RST_INT_MASK), 32'h0000_0001 << pcias_pkg::ST_EMPTY};

    pcias_top pcias_top_inst (.pclk, .presetn, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .req_n, .gnt_n,
        .isa_hold_req_n, .isa_hold_ack_n, .gfx_sys_err_in_n, .perr_n,
        .devsel_n, .trdy_n, .stop_n, .frame_n, .irdy_n, .own_cycle,
        .addr_par_err, .post_buf_empty, .post_flush, .post_disable,
        .serr_o, .serr_oe, .data_beat, .master_stop, .irq);
    pcias_isa_model pcias_isa_model_inst (.pclk, .presetn, .go, .fill,
        .fill_n, .hold_len, .isa_hold_ack_n, .post_flush, .post_disable,
        .isa_hold_req_n, .post_buf_empty);

    always #5 pclk = ~pclk;

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard well above the under one thousand cycles the run needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (serr_oe === 1'b1) serr_seen <= serr_seen + 1;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pins(input logic v);
        case (cause)
            1: perr_n <= v;
            2: gfx_sys_err_in_n <= v;
            default: begin
                // abort is stop with devsel and trdy left high
                own_cycle <= ~v;
                {stop_n, irdy_n, frame_n} <= {3{v}};
            end
        endcase
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("reset grants", gnt_n, 3'h7);
        check("reset ack", isa_hold_ack_n, 1'b1);
        check("reset serr", serr_oe, 1'b0);
        foreach (offs[i]) begin
            apb(1'b0, offs[i], 32'h0000_0000);
            check("reset reg", q, rstv[i]);
            check("reset err", e, 1'b0);
        end
        apb(1'b0, 8'h40, 32'h0000_0000);
        check("unmapped err", e, 1'b1);
        check("unmapped data", q, 32'h0000_0000);
        for (int n = 0; n < 16; n++) begin
            r = rnd();
            cause = r[1:0];
            apb(1'b1, pcias_pkg::OFF_PCI_CMD, r & 32'h0000_0140);
            apb(1'b1, pcias_pkg::OFF_ERR_CMD, r & 32'h0000_0028);
            apb(1'b1, pcias_pkg::OFF_PAR_SERR, {31'h0, r[10]});
            apb(1'b1, pcias_pkg::OFF_INT_MASK, {29'h0, r[14:12]});
            s0 = serr_seen;
            @(posedge pclk);
            if (cause == 0) addr_par_err <= 1'b1;
            else pins(1'b0);
            @(posedge pclk);
            addr_par_err <= 1'b0;
            repeat (3) @(posedge pclk);
            check("master stop", master_stop, cause == 3);
            if (cause != 0) pins(1'b1);
            repeat (8) @(posedge pclk);
            xs = (cause == 0) ? r[8] & r[6] & r[10] :
                 (cause == 1) ? r[8] & r[3] : (cause == 2) ? r[8] & r[5] :
                 r[8];
            case (cause)
                0: check("apar serr", serr_seen - s0, xs);
                1: check("perr serr", serr_seen - s0, xs);
                2: check("gfx serr", serr_seen - s0, xs);
                default: check("abort serr", serr_seen - s0, xs);
            endcase
            apb(1'b0, pcias_pkg::OFF_INT_STAT, 32'h0000_0000);
            g3 = {cause == 3, 1'b0, xs[0]};
            check("int stat", q & 32'h7, g3);
            check("irq", irq, |(g3 & r[14:12]));
            apb(1'b1, pcias_pkg::OFF_INT_STAT, 32'h0000_0007);
            repeat (2) @(posedge pclk);
            check("irq clear", irq, 1'b0);
        end
        own_cycle <= 1'b1;
        {devsel_n, trdy_n, irdy_n} <= 3'h0;
        repeat (4) @(posedge pclk);
        check("data beat", data_beat, 1'b1);
        check("beat no stop", master_stop, 1'b0);
        own_cycle <= 1'b0;
        {devsel_n, trdy_n, irdy_n} <= 3'h7;
        repeat (4) @(posedge pclk);
        check("beat end", data_beat, 1'b0);
        req_n <= 3'h0;
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 20 && gnt_n === 3'h7; i++) @(posedge pclk);
            g3 = ~(3'h1 << k);
            check("grant order", gnt_n, g3);
            req_n[k] <= 1'b1;
            for (int i = 0; i < 20 && gnt_n !== 3'h7; i++) @(posedge pclk);
        end
        for (int h = 0; h < 2; h++) begin
            req_n  <= 3'h6;
            fill   <= 1'b1;
            fill_n <= 4'(h * 9);
            @(posedge pclk);
            fill <= 1'b0;
            for (int i = 0; i < 20 && gnt_n === 3'h7; i++) @(posedge pclk);
            go <= 1'b1;
            @(posedge pclk);
            go <= 1'b0;
            for (int i = 0; i < 60 && isa_hold_ack_n !== 1'b0; i++)
                @(posedge pclk);
            check("hold ack", isa_hold_ack_n, 1'b0);
            check("buffer empty", post_buf_empty, 1'b1);
            check("posting off", post_disable, 1'b1);
            check("no grant", gnt_n, 3'h7);
            apb(1'b0, pcias_pkg::OFF_STATUS, 32'h0000_0000);
            check("hold state", q[1:0], 2'h3);
            for (int i = 0; i < 60 && isa_hold_ack_n !== 1'b1; i++)
                @(posedge pclk);
            apb(1'b0, pcias_pkg::OFF_INT_STAT, 32'h0000_0000);
            check("ack event", q[1], 1'b1);
            apb(1'b1, pcias_pkg::OFF_INT_STAT, 32'h0000_0007);
            for (int i = 0; i < 20 && gnt_n === 3'h7; i++) @(posedge pclk);
            check("grant back", gnt_n, 3'h6);
            req_n <= 3'h7;
            repeat (6) @(posedge pclk);
        end
        final_report();
    end
endmodule
